//--- rtl/addr_bus_arbiter.sv
// Address bus arbiter for an internal master and three external masters.
// Assumes all bus observation inputs are synchronous to CLK_I.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
// Function
// - Arbiter enabled only if both ident straps sampled high at reset release.
// - Arbiter-present status bit mirrors enable; clear under external arbitration.
// - Only address bus granted; masters order data bus themselves.
// - Four participants: internal master plus three external request/grant pairs.
// - Internal master request always wins over external requests.
// - Round-robin among externals; last granted becomes lowest priority.
// - Ungranted external requester gains priority for next arbitration.
// - Each external request individually enabled; all enabled after reset.
// - Parking grants idle bus to last or default master per control bits.
// - Pipeline workaround keeps single-level pipelining for external grants; code withholds them while any data tenure is outstanding.
// - Pipeline workaround has own bit, disabled after reset.
// - Benign retry mode withholds external grants briefly after a benign retry.
// - Benign retry mode has own bit, enabled after reset.
module addr_bus_arbiter #(
  parameter int HOLDOFF = arb_pkg::HOLDOFF_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [1:0] PROC_IDENT_STRAP_I,
  input wire logic INT_REQ_I,
  output logic INT_GNT_O,
  input wire logic [2:0] EXT_REQ_I,
  output logic [2:0] EXT_GNT_O,
  input wire logic ADDR_START_I,
  input wire logic ADDR_ACK_I,
  input wire logic ADDR_RETRY_I,
  input wire logic DATA_DONE_I,
  output logic ARBITER_ENABLED_O,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O
);
  typedef enum logic [1:0] {GNT_NONE, GNT_INT, GNT_EXT} gnt_state_type;

  logic strap_done, next_strap_done;
  logic arb_en, next_arb_en;
  arb_pkg::arbiter_control_type ctrl, next_ctrl;
  logic wr_pend, next_wr_pend;
  logic [11:0] wr_addr, next_wr_addr;
  logic [31:0] rdata, next_rdata;
  gnt_state_type state, next_state;
  logic [1:0] owner, next_owner;
  logic [1:0] last, next_last;
  logic [1:0] last_ext, next_last_ext;
  logic [1:0] pipe_depth, next_pipe_depth;
  logic [$clog2(HOLDOFF + 1) - 1:0] hold, next_hold;
  logic int_gnt, next_int_gnt;
  logic [2:0] ext_gnt, next_ext_gnt;
  logic [2:0] ext_live;
  logic [1:0] pick;
  logic pick_ok;
  logic ext_blocked;
  logic addr_phase;

  // Round-robin: search starts just after the last external granted
  function automatic logic [2:0] rr_pick(input logic [2:0] req, input logic [1:0] last_idx);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int k = 1; k <= arb_pkg::NUM_EXT; k++) begin
      idx = 2'((int'(last_idx) + k) % arb_pkg::NUM_EXT);
      if (req[idx] && res == 3'h0) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : rr_pick

  function automatic logic [2:0] onehot3(input logic [1:0] idx);
    return 3'(3'h1 << idx);
  endfunction : onehot3

  // Strap capture and register port
  always_comb begin
    next_strap_done = 1'b1;
    next_arb_en = arb_en;
    if (!strap_done) begin
      next_arb_en = &PROC_IDENT_STRAP_I;
    end
    next_ctrl = ctrl;
    next_rdata = rdata;
    addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
    next_wr_pend = addr_phase && HWRITE_I;
    next_wr_addr = addr_phase ? HADDR_I[11:0] : wr_addr;
    if (wr_pend && wr_addr == arb_pkg::OFS_ARBITER_CONTROL) begin
      next_ctrl.req_en = HWDATA_I[arb_pkg::BIT_REQ_EN +: 3];
      next_ctrl.park_en = HWDATA_I[arb_pkg::BIT_PARK_EN];
      next_ctrl.park_mode = HWDATA_I[arb_pkg::BIT_PARK_MODE];
      next_ctrl.default_master = HWDATA_I[arb_pkg::BIT_DEFAULT_MASTER +: 2];
      next_ctrl.pipeline_workaround_enable = HWDATA_I[arb_pkg::BIT_PIPELINE_WA];
      next_ctrl.benign_retry_mode_enable = HWDATA_I[arb_pkg::BIT_BENIGN_RETRY];
    end
    if (addr_phase && !HWRITE_I) begin
      next_rdata = 32'h0;
      if (HADDR_I[11:0] == arb_pkg::OFS_ARBITER_CONTROL) begin
        next_rdata[arb_pkg::BIT_REQ_EN +: 3] = ctrl.req_en;
        next_rdata[arb_pkg::BIT_PARK_EN] = ctrl.park_en;
        next_rdata[arb_pkg::BIT_PARK_MODE] = ctrl.park_mode;
        next_rdata[arb_pkg::BIT_DEFAULT_MASTER +: 2] = ctrl.default_master;
        next_rdata[arb_pkg::BIT_PIPELINE_WA] = ctrl.pipeline_workaround_enable;
        next_rdata[arb_pkg::BIT_BENIGN_RETRY] = ctrl.benign_retry_mode_enable;
      end else if (HADDR_I[11:0] == arb_pkg::OFS_GLOBAL_CONTROL_STATUS) begin
        next_rdata[arb_pkg::BIT_ARBITER_PRESENT] = arb_en;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      strap_done <= 1'b0;
      arb_en <= 1'b0;
      ctrl <= '{req_en: arb_pkg::RST_REQ_EN, park_en: arb_pkg::RST_PARK_EN,
                park_mode: arb_pkg::RST_PARK_MODE, default_master: arb_pkg::RST_DEFAULT_MASTER,
                pipeline_workaround_enable: arb_pkg::RST_PIPELINE_WA,
                benign_retry_mode_enable: arb_pkg::RST_BENIGN_RETRY};
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      rdata <= 32'h0;
    end else begin
      strap_done <= next_strap_done;
      arb_en <= next_arb_en;
      ctrl <= next_ctrl;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rdata <= next_rdata;
    end
  end

  // Arbitration; owner code 0..2 external, 3 internal
  always_comb begin
    logic [2:0] rr;
    logic [1:0] park_to;
    park_to = ctrl.park_mode ? ctrl.default_master : last;
    ext_live = EXT_REQ_I & ctrl.req_en;
    rr = rr_pick(ext_live, last_ext);
    pick_ok = rr[2];
    pick = rr[1:0];
    next_state = state;
    next_owner = owner;
    next_last = last;
    next_last_ext = last_ext;
    next_pipe_depth = pipe_depth;
    next_hold = hold;
    // Tenure tracking: up to three data tenures may trail their address tenures
    if (ADDR_ACK_I && !ADDR_RETRY_I && !DATA_DONE_I && pipe_depth != 2'h3) begin
      next_pipe_depth = pipe_depth + 2'h1;
    end else if (DATA_DONE_I && !(ADDR_ACK_I && !ADDR_RETRY_I) && pipe_depth != 2'h0) begin
      next_pipe_depth = pipe_depth - 2'h1;
    end
    if (ctrl.benign_retry_mode_enable && ADDR_ACK_I && ADDR_RETRY_I) begin
      next_hold = ($bits(hold))'(HOLDOFF);
    end else if (hold != '0) begin
      next_hold = hold - 1'b1;
    end
    ext_blocked = (hold != '0) ||
                  (ctrl.pipeline_workaround_enable && pipe_depth != 2'h0);
    unique case (state)
      GNT_NONE: begin
        if (INT_REQ_I) begin
          next_state = GNT_INT;
          next_owner = 2'h3;
        end else if (pick_ok && !ext_blocked) begin
          next_state = GNT_EXT;
          next_owner = pick;
        end else if (ctrl.park_en) begin
          if (park_to == 2'h3) begin
            next_state = GNT_INT;
            next_owner = 2'h3;
          end else if (ctrl.req_en[park_to] && !ext_blocked) begin
            next_state = GNT_EXT;
            next_owner = park_to;
          end
        end
      end
      // Grant ends when the owner starts its address tenure, or earlier on preemption, request loss, disable or blocking; data order left to masters
      GNT_INT: begin
        // Parked grant moves when the park target is reprogrammed
        if (ADDR_START_I || (!INT_REQ_I && (ext_live != 3'h0 || !ctrl.park_en || park_to != 2'h3))) begin
          next_state = GNT_NONE;
          next_last = 2'h3;
        end
      end
      GNT_EXT: begin
        if (ADDR_START_I || INT_REQ_I || !ctrl.req_en[owner] || ext_blocked ||
            (!EXT_REQ_I[owner] && (ext_live != 3'h0 || !ctrl.park_en || park_to != owner))) begin
          next_state = GNT_NONE;
          if (ADDR_START_I) begin
            next_last = owner;
            next_last_ext = owner;
          end
        end
      end
    endcase
    if (!arb_en) begin
      next_state = GNT_NONE;
    end
    next_int_gnt = next_state == GNT_INT;
    next_ext_gnt = (next_state == GNT_EXT) ? onehot3(next_owner) : 3'h0;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= GNT_NONE;
      owner <= 2'h3;
      last <= 2'h3;
      last_ext <= 2'h2;
      pipe_depth <= 2'h0;
      hold <= '0;
      int_gnt <= 1'b0;
      ext_gnt <= 3'h0;
    end else begin
      state <= next_state;
      owner <= next_owner;
      last <= next_last;
      last_ext <= next_last_ext;
      pipe_depth <= next_pipe_depth;
      hold <= next_hold;
      int_gnt <= next_int_gnt;
      ext_gnt <= next_ext_gnt;
    end
  end

  assign INT_GNT_O = int_gnt;
  assign EXT_GNT_O = ext_gnt;
  assign ARBITER_ENABLED_O = arb_en;
  assign HRDATA_O = rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
endmodule : addr_bus_arbiter

//--- rtl/arb_pkg.sv
// Constants and carrier types for the processor address bus arbiter.
// Assumes a single 250 MHz clock and an AHB-Lite register port.
package arb_pkg;
  localparam int NUM_EXT = 3;
  localparam logic [11:0] OFS_ARBITER_CONTROL = 12'h000;
  localparam logic [11:0] OFS_GLOBAL_CONTROL_STATUS = 12'h004;
  // Control field positions
  localparam int BIT_REQ_EN = 0;
  localparam int BIT_PARK_EN = 4;
  localparam int BIT_PARK_MODE = 5;
  localparam int BIT_DEFAULT_MASTER = 6;
  localparam int BIT_PIPELINE_WA = 8;
  localparam int BIT_BENIGN_RETRY = 9;
  localparam int BIT_ARBITER_PRESENT = 0;
  localparam logic [2:0] RST_REQ_EN = 3'h7;
  localparam logic RST_PARK_EN = 1'b0;
  localparam logic RST_PARK_MODE = 1'b0;
  localparam logic [1:0] RST_DEFAULT_MASTER = 2'h0;
  localparam logic RST_PIPELINE_WA = 1'b0;
  localparam logic RST_BENIGN_RETRY = 1'b1;
  // Hold-off after a benign retry
  localparam int HOLDOFF_NS = 40;
  localparam int CLK_PERIOD_NS = 4;
  localparam int HOLDOFF_CYCLES = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [2:0] req_en;
    logic park_en;
    logic park_mode;
    logic [1:0] default_master;
    logic pipeline_workaround_enable;
    logic benign_retry_mode_enable;
  } arbiter_control_type;

  typedef struct packed {
    logic [2:0] req;
    logic int_req;
    logic addr_start;
    logic addr_ack;
    logic addr_retry;
    logic data_done;
  } bus_obs_type;
endpackage : arb_pkg

//--- sim/addr_bus_arbiter_sva.sv
// Port-level checker for the address bus arbiter.
// Assumes benign retries are only raised while that mode is on.
`timescale 1ns/1ns
module addr_bus_arbiter_sva #(
  parameter int HOLDOFF = 2
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic INT_REQ_I,
  input wire logic INT_GNT_O,
  input wire logic [2:0] EXT_GNT_O,
  input wire logic ADDR_START_I,
  input wire logic ADDR_ACK_I,
  input wire logic ADDR_RETRY_I,
  input wire logic ARBITER_ENABLED_O
);
  logic [3:0] g;
  assign g = {INT_GNT_O, EXT_GNT_O};
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_one_grant: assert property ($onehot0(g))
    else $error("more than one grant");
  a_strap_off_idle: assert property (!ARBITER_ENABLED_O |-> g == 4'h0)
    else $error("grant without arbiter");
  a_enable_stable: assert property ($past(RSTN_I, 2) |-> $stable(ARBITER_ENABLED_O))
    else $error("enable changed after capture");
  a_int_preempts: assert property (INT_REQ_I |=> EXT_GNT_O == 3'h0)
    else $error("external grant beside internal request");
  a_int_served: assert property ($rose(INT_REQ_I) && ARBITER_ENABLED_O |-> ##[1:4] INT_GNT_O)
    else $error("internal request not granted");
  a_start_ends_grant: assert property (ADDR_START_I && g != 4'h0 |=> g == 4'h0)
    else $error("grant held past tenure start");
  a_handover_idle: assert property ($changed(g) && $past(g) != 4'h0 |-> g == 4'h0)
    else $error("grant passed without idle cycle");
  a_retry_holdoff: assert property (ADDR_ACK_I && ADDR_RETRY_I |-> ##2 EXT_GNT_O == 3'h0)
    else $error("external grant during hold-off");
  c_int: cover property (INT_GNT_O);
  c_ext2: cover property (EXT_GNT_O == 3'h4);
  c_retry: cover property (ADDR_ACK_I && ADDR_RETRY_I);
endmodule : addr_bus_arbiter_sva
bind addr_bus_arbiter addr_bus_arbiter_sva #(.HOLDOFF(HOLDOFF)) u_addr_bus_arbiter_sva (.CLK_I(CLK_I),
  .RSTN_I(RSTN_I), .INT_REQ_I(INT_REQ_I), .INT_GNT_O(INT_GNT_O), .EXT_GNT_O(EXT_GNT_O),
  .ADDR_START_I(ADDR_START_I), .ADDR_ACK_I(ADDR_ACK_I), .ADDR_RETRY_I(ADDR_RETRY_I),
  .ARBITER_ENABLED_O(ARBITER_ENABLED_O));

//--- sim/ext_master_model.sv
// Three external bus masters: request on demand, start a tenure once granted.
// Assumes grants are registered and sampled at the rising edge.
`timescale 1ns/1ns
module ext_master_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic [2:0] want_i,
  input wire logic [2:0] gnt_i,
  output logic [2:0] req_o,
  output logic start_o
);
  logic [2:0] done;
  logic seen;
  logic hit;
  assign hit = |(gnt_i & req_o);
  // Request dropped once served, so a parked grant never starts a tenure
  assign req_o = want_i & ~done;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done <= 3'h0;
      seen <= 1'b0;
      start_o <= 1'b0;
    end else begin
      seen <= hit;
      // Slow masters wait one extra cycle before starting
      start_o <= hit & !start_o & (!slow_i | seen);
      done <= (done | (start_o ? 3'h0 : gnt_i & req_o & {3{!slow_i | seen}})) & want_i;
    end
  end
endmodule : ext_master_model

//--- sim/tb_processor_address_bus_arbiter.sv
// Testbench for the address bus arbiter with its register port.
// Assumes zero-wait AHB-Lite answers and a short hold-off parameter.
`timescale 1ns/1ns
module tb_processor_address_bus_arbiter;
  logic CLK_I = 1'b0, RSTN_I = 1'b0, INT_REQ_I = 1'b0, int_start = 1'b0, slow = 1'b0;
  logic ack = 1'b0, retry = 1'b0, fin = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] strap = 2'h3, htrans = 2'h0;
  logic [2:0] want = 3'h0, ext_req, EXT_GNT_O;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, HRDATA_O;
  logic INT_GNT_O, ARBITER_ENABLED_O, HREADYOUT_O, HRESP_O, m_start;
  logic [3:0] g, gs [3];
  int err_count = 0, tests_run = 0, i;
  always #2 CLK_I = ~CLK_I;
  addr_bus_arbiter #(.HOLDOFF(2)) u_addr_bus_arbiter (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PROC_IDENT_STRAP_I(strap),
    .INT_REQ_I(INT_REQ_I), .INT_GNT_O(INT_GNT_O), .EXT_REQ_I(ext_req), .EXT_GNT_O(EXT_GNT_O),
    .ADDR_START_I(m_start | int_start), .ADDR_ACK_I(ack), .ADDR_RETRY_I(retry), .DATA_DONE_I(fin),
    .ARBITER_ENABLED_O(ARBITER_ENABLED_O), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O));
  ext_master_model u_ext_master_model (.clk_i(CLK_I), .rstn_i(RSTN_I), .slow_i(slow), .want_i(want),
    .gnt_i(EXT_GNT_O), .req_o(ext_req), .start_o(m_start));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
    r = HRDATA_O;
  endtask : bus
  task grab(output logic [3:0] gg);
    gg = 4'h0;
    for (int n = 0; n < 40 && gg == 4'h0; n++) begin
      @(posedge CLK_I);
      gg = {INT_GNT_O, EXT_GNT_O};
    end
  endtask : grab
  task release_all();
    while (EXT_GNT_O !== 3'h0) @(posedge CLK_I);
    want <= 3'h0;
    repeat (3) @(posedge CLK_I);
  endtask : release_all
  task restart(input logic [1:0] s);
    RSTN_I <= 1'b0;
    strap <= s;
    repeat (4) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
  endtask : restart
  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    restart(2'h3);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, 32'h0000_0207);
    bus(1'b0, 32'h4, 32'h0);
    chk(r, 32'h1);
    bus(1'b0, 32'h10, 32'h0);
    chk(r, 32'h0);
    $display("register test done");
    slow <= 1'b1;
    for (i = 0; i < 3; i++) begin
      want <= 3'h7;
      grab(gs[i]);
      release_all();
    end
    chk(gs[0] | gs[1] | gs[2], 32'h7);
    slow <= 1'b0;
    $display("round-robin test done");
    want <= 3'h7;
    INT_REQ_I <= 1'b1;
    grab(g);
    chk(g, 32'h8);
    int_start <= 1'b1;
    INT_REQ_I <= 1'b0;
    @(posedge CLK_I);
    int_start <= 1'b0;
    grab(g);
    chk(g[3], 32'h0);
    release_all();
    bus(1'b1, 32'h0, 32'h205);
    want <= 3'h2;
    repeat (12) @(posedge CLK_I);
    chk(EXT_GNT_O, 32'h0);
    want <= 3'h0;
    bus(1'b1, 32'h0, 32'h2f7);
    repeat (6) @(posedge CLK_I);
    chk({INT_GNT_O, EXT_GNT_O}, 32'h8);
    bus(1'b1, 32'h0, 32'h277);
    repeat (6) @(posedge CLK_I);
    chk({INT_GNT_O, EXT_GNT_O}, 32'h2);
    bus(1'b1, 32'h0, 32'h207);
    $display("enable and parking test done");
    ack <= 1'b1;
    retry <= 1'b1;
    want <= 3'h1;
    @(posedge CLK_I);
    ack <= 1'b0;
    retry <= 1'b0;
    grab(g);
    chk(g, 32'h1);
    release_all();
    bus(1'b1, 32'h0, 32'h307);
    ack <= 1'b1;
    @(posedge CLK_I);
    ack <= 1'b0;
    want <= 3'h4;
    repeat (8) @(posedge CLK_I);
    chk(EXT_GNT_O, 32'h0);
    fin <= 1'b1;
    @(posedge CLK_I);
    fin <= 1'b0;
    grab(g);
    chk(g, 32'h4);
    release_all();
    $display("retry and pipeline test done");
    restart(2'h1);
    bus(1'b0, 32'h4, 32'h0);
    chk(r, 32'h0);
    INT_REQ_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    chk(INT_GNT_O, 32'h0);
    INT_REQ_I <= 1'b0;
    $display("strap test done");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge CLK_I);
    err_count++;
    give_verdict();
  end
endmodule : tb_processor_address_bus_arbiter
